/* File: spe_far_dev.sv */
// far-end storage device model: link events toward the port, acks its data frames
`timescale 1ns/1ps
module spe_far_dev (
   input  wire logic             sys_clk_i,
   input  wire logic             tx_data_frame_i,
   input  wire logic             nak_data_i,
   output spe_pkg::spe_link_ev_t link_ev_o
);
   spe_pkg::spe_link_ev_t frm = '0;
   spe_pkg::spe_link_ev_t ack = '0;
   int                    acks = 0;
   // pulses idle at zero, so merging frames and acks needs no arbitration
   assign link_ev_o = spe_pkg::spe_link_ev_t'(frm | ack);
   // =========================================================
   // one r_ok or r_err per data frame, a cycle later
   always @(posedge sys_clk_i) begin
      ack <= '0;
      if (tx_data_frame_i === 1'b1) begin
         ack.tx_done_ok  <= !nak_data_i;
         ack.tx_done_err <= nak_data_i;
         ack.tx_is_data  <= 1'b1;
         acks <= acks + 1;
      end
   end
   task automatic send(input spe_pkg::spe_link_ev_t ev);
      @(posedge sys_clk_i);
      frm <= ev;
      @(posedge sys_clk_i);
      frm <= '0;
   endtask
endmodule // spe_far_dev

/* File: spe_pkg.sv */
// spe_pkg: shared constants and carriers for the port error reporting block
package spe_pkg;

   // =========================================================
   // register map (byte offsets, byte address = offset)
   localparam logic [7:0] ADDR_STATUS  = 8'h00;
   localparam logic [7:0] ADDR_ENABLE  = 8'h04;
   localparam logic [7:0] ADDR_LINKERR = 8'h08;
   localparam logic [7:0] ADDR_CONTROL = 8'h0C;
   localparam logic [7:0] ADDR_ISSUED  = 8'h10;
   localparam logic [7:0] ADDR_QUEUED  = 8'h14;
   localparam logic [7:0] ADDR_STATE   = 8'h18;

   // =========================================================
   // status / enable bit positions
   localparam int ST_HBF = 0;
   localparam int ST_HBD = 1;
   localparam int ST_IFF = 2;
   localparam int ST_INF = 3;
   localparam int STATUS_W = 4;

   // link error register bit positions
   localparam int LE_PROTO = 0;
   localparam int LE_DISP  = 1;
   localparam int LE_CRC   = 2;
   localparam int LE_HSHK  = 3;
   localparam int LINKERR_W = 4;

   // control register bit positions
   localparam int CT_RUN  = 0;
   localparam int CT_GIE  = 1;

   // =========================================================
   // frame limits
   localparam logic [13:0] UNKNOWN_MAX_BYTES = 14'h0040;
   localparam logic [13:0] DATA_MAX_BYTES    = 14'h2000;

   // =========================================================
   // link events from the transport/link layer, one-cycle pulses
   typedef struct packed {
      logic        rx_frame_end;   // received frame finished
      logic        rx_is_data;     // received frame is a data frame
      logic        rx_known;       // supported frame type
      logic        rx_len_ok;      // length legal for the type
      logic [13:0] rx_len;         // byte length
      logic        rx_crc_bad;     // computed crc differs
      logic        rx_disp_d;      // disparity/illegal data character
      logic        rx_disp_k;      // disparity/illegal K28.3
      logic        rx_overflow;    // late hold acknowledge
      logic        rx_in_frame;    // a frame is in progress
      logic        rx_d2h_reg;     // device-to-host register frame
      logic        rx_clears_all;  // busy, data request, error all clear
      logic        rx_upd_bsy_drq; // frame would update busy and drq
      logic        rx_dma_activate;// dma activate frame
      logic [4:0]  rx_slot;        // slot the frame refers to
      logic        tx_done_ok;     // transmitted frame got r_ok
      logic        tx_done_err;    // transmitted frame got r_err
      logic        tx_is_data;     // transmitted frame is data
   } spe_link_ev_t;

   // system memory events, one-cycle pulses
   typedef struct packed {
      logic abort;        // master/target abort
      logic data_err;     // data error
      logic on_fetch;     // during command frame/entry/list fetch
      logic on_payload;   // during payload or packet-command field
   } spe_mem_ev_t;

   typedef enum logic [1:0] {
      RSP_NONE,
      RSP_OK,
      RSP_ERR
   } spe_resp_t;

endpackage : spe_pkg

/* File: spe_port_err.sv */
// spe_port_err: per-port error detection, classification and reporting
`timescale 1ns/1ps
// Behaviour
// [RULE1] errors recorded per port only, none global
// [RULE2] abort then set fatal flag, interrupt gated
// [RULE3] fetch data error stops command processing
// [RULE4] data error sets data flag, interrupt gated
// [RULE5] continuing after payload error poisons crc
// [RULE6] proto, crc, handshake, phy drop set flag
// [RULE7] data frame fatal, non-data non-fatal retried
// [RULE8] accept incoming frames before retrying failed one
// [RULE9] retry non-data until success or stop
// [RULE10] K28.3 disparity resets decoder, no bits
// [RULE11] data char disparity: r_err, disparity bit
// [RULE12] phy drop returns idle, outside frame silent
// [RULE13] bad crc: r_err, idle, crc bit
// [RULE14] illegal length: r_err, no post, protocol
// [RULE15] buffer overflow: r_err, protocol bit
// [RULE16] far end r_err sets handshake bit
// [RULE17] stale busy update answered ok, ignored
// [RULE18] non-data frame posted only once valid
// [RULE19] interleaved frames from other ports handled
// [RULE20] clearing register frame clears issued slot
// [RULE21] next slot issued after completion per port
// [RULE22] each dma activate sends one data frame; code sends none for a bad activate, with tx_more_data_i low or when stopped
// [RULE23] interrupt is flag and enable and global
module spe_port_err #(
   parameter int SLOTS = 32
) (
   input  wire logic                 sys_clk_i,
   input  wire logic                 srst_i,
   input  wire logic [7:0]           reg_addr_i,
   input  wire logic [31:0]          reg_wdata_i,
   input  wire logic                 reg_wr_i,
   input  wire logic                 reg_rd_i,
   output logic      [31:0]          reg_rdata_o,
   input  wire logic                 phy_link_up_i,
   input  spe_pkg::spe_link_ev_t     link_ev_i,
   input  spe_pkg::spe_mem_ev_t      mem_ev_i,
   input  wire logic                 tx_more_data_i,
   output spe_pkg::spe_resp_t        rx_resp_o,
   output logic                      rx_post_o,
   output logic                      decoder_disp_reset_o,
   output logic                      tx_crc_poison_o,
   output logic                      tx_retry_o,
   output logic                      tx_data_frame_o,
   output logic                      cmd_stopped_o,
   output logic                      port_idle_o,
   output logic      [4:0]           done_slot_o,
   output logic                      done_valid_o,
   output logic                      irq_o
);

   // =========================================================
   // phy ready synchroniser
   logic phy_meta;
   logic phy_sync;
   logic phy_prev;
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         phy_meta <= 1'b0;
         phy_sync <= 1'b0;
         phy_prev <= 1'b0;
      end else begin
         phy_meta <= phy_link_up_i;
         phy_sync <= phy_meta;
         phy_prev <= phy_sync;
      end
   end
   logic phy_drop;
   assign phy_drop = phy_prev & ~phy_sync;

   // =========================================================
   // software registers
   logic [spe_pkg::STATUS_W-1:0]  status;
   logic [spe_pkg::STATUS_W-1:0]  int_enable;
   logic [spe_pkg::LINKERR_W-1:0] link_error_register;
   logic                          port_run_bit;
   logic                          global_interrupt_enable;
   logic [SLOTS-1:0]              issued_command_bits;
   logic [SLOTS-1:0]              queued_active_bits;
   logic                          taskfile_busy;
   logic                          taskfile_data_request;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   // =========================================================
   // receive classification
   logic rx_end;
   logic rx_stale;
   logic rx_len_bad;
   logic rx_bad;
   logic in_frame;
   assign rx_end     = link_ev_i.rx_frame_end;
   assign in_frame   = link_ev_i.rx_in_frame;
   // stale busy/drq update is valid when enumerating behind a multiplier
   assign rx_stale   = link_ev_i.rx_upd_bsy_drq & ~taskfile_busy & ~taskfile_data_request; // RULE17
   assign rx_len_bad = link_ev_i.rx_known ? ~link_ev_i.rx_len_ok
                                          : (link_ev_i.rx_len > spe_pkg::UNKNOWN_MAX_BYTES); // RULE14
   logic disp_seen;
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         disp_seen <= 1'b0;
      end else if (rx_end | phy_drop) begin
         disp_seen <= 1'b0;
      end else if (link_ev_i.rx_disp_d & in_frame) begin
         disp_seen <= 1'b1; // RULE11
      end
   end
   logic ovf_seen;
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         ovf_seen <= 1'b0;
      end else if (rx_end | phy_drop) begin
         ovf_seen <= 1'b0;
      end else if (link_ev_i.rx_overflow) begin
         ovf_seen <= 1'b1; // RULE15
      end
   end
   // an event in the frame-end cycle counts too, the end clears the latches
   logic disp_any;
   logic ovf_any;
   assign disp_any = disp_seen | (link_ev_i.rx_disp_d & in_frame); // RULE11
   assign ovf_any  = ovf_seen | link_ev_i.rx_overflow;             // RULE15
   assign rx_bad = link_ev_i.rx_crc_bad | rx_len_bad | disp_any | ovf_any;

   // response and posting at frame end
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         rx_resp_o <= spe_pkg::RSP_NONE;
         rx_post_o <= 1'b0;
      end else begin
         rx_resp_o <= spe_pkg::RSP_NONE;
         rx_post_o <= 1'b0;
         if (rx_end) begin
            if (rx_bad & ~rx_stale) begin
               rx_resp_o <= spe_pkg::RSP_ERR; // RULE13 RULE14 RULE15 RULE11
            end else begin
               rx_resp_o <= spe_pkg::RSP_OK;
               // data frames already went to memory; others post only now
               rx_post_o <= ~rx_stale & ~link_ev_i.rx_is_data; // RULE18 RULE17
            end
         end
      end
   end

   assign decoder_disp_reset_o = link_ev_i.rx_disp_k; // RULE10

   // =========================================================
   // link error register, set wins over write-one-to-clear
   logic [spe_pkg::LINKERR_W-1:0] le_set;
   always_comb begin
      le_set = '0;
      if (rx_end & ~rx_stale) begin
         le_set[spe_pkg::LE_CRC]   = link_ev_i.rx_crc_bad;   // RULE13
         le_set[spe_pkg::LE_PROTO] = rx_len_bad | ovf_any;   // RULE14 RULE15
         le_set[spe_pkg::LE_DISP]  = disp_any;               // RULE11
      end
      le_set[spe_pkg::LE_HSHK] = link_ev_i.tx_done_err;     // RULE16
   end
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         link_error_register <= '0;
      end else begin
         link_error_register <= (link_error_register
            & ~((reg_wr_i && hit(reg_addr_i, spe_pkg::ADDR_LINKERR))
                ? reg_wdata_i[spe_pkg::LINKERR_W-1:0] : '0)) | le_set;
      end
   end

   // =========================================================
   // interface error classification
   logic if_err;
   logic if_data;
   logic phy_in_frame;
   assign phy_in_frame = phy_drop & in_frame;            // RULE12
   assign if_err  = le_set[spe_pkg::LE_CRC] | le_set[spe_pkg::LE_PROTO]
                  | le_set[spe_pkg::LE_HSHK] | phy_in_frame; // RULE6
   assign if_data = link_ev_i.tx_done_err ? link_ev_i.tx_is_data : link_ev_i.rx_is_data;

   // =========================================================
   // retry and stop control
   logic retry_pend;
   logic data_halt;
   always_ff @(posedge sys_clk_i) begin
      if (srst_i | ~port_run_bit) begin
         retry_pend <= 1'b0;
         data_halt  <= 1'b0;
      end else begin
         if (link_ev_i.tx_done_err & ~link_ev_i.tx_is_data) begin
            retry_pend <= 1'b1; // RULE7 RULE9
         end else if (link_ev_i.tx_done_ok) begin
            retry_pend <= 1'b0;
         end
         if (if_err & if_data) begin
            data_halt <= 1'b1;  // RULE7 RULE9
         end
      end
   end
   // incoming frames take the link first, retry only when quiet
   assign tx_retry_o = retry_pend & ~in_frame & ~rx_end & ~data_halt; // RULE8 RULE19

   logic fetch_stop;
   logic poison;
   always_ff @(posedge sys_clk_i) begin
      if (srst_i | ~port_run_bit) begin
         fetch_stop <= 1'b0;
         poison     <= 1'b0;
      end else begin
         if (mem_ev_i.abort | (mem_ev_i.data_err & mem_ev_i.on_fetch)) begin
            fetch_stop <= 1'b1; // RULE3 RULE2
         end
         if (mem_ev_i.data_err & mem_ev_i.on_payload) begin
            poison <= 1'b1;     // RULE5
         end
      end
   end
   assign tx_crc_poison_o = poison;                      // RULE5
   assign cmd_stopped_o   = fetch_stop | data_halt | ~port_run_bit;

   logic idle;
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         idle <= 1'b1;
      end else if (phy_drop | (rx_end & rx_bad)) begin
         idle <= 1'b1; // RULE12 RULE13 RULE14
      end else if (in_frame) begin
         idle <= 1'b0;
      end
   end
   assign port_idle_o = idle;

   // one data frame per dma activate while count remains
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         tx_data_frame_o <= 1'b0;
      end else begin
         tx_data_frame_o <= link_ev_i.rx_dma_activate & rx_end & ~rx_bad
                            & tx_more_data_i & ~cmd_stopped_o; // RULE22
      end
   end

   // =========================================================
   // port status flags, set wins over write-one-to-clear
   logic [spe_pkg::STATUS_W-1:0] st_set;
   always_comb begin
      st_set = '0;
      st_set[spe_pkg::ST_HBF] = mem_ev_i.abort;              // RULE2
      st_set[spe_pkg::ST_HBD] = mem_ev_i.data_err;           // RULE4
      st_set[spe_pkg::ST_IFF] = if_err & if_data;            // RULE7
      st_set[spe_pkg::ST_INF] = if_err & ~if_data;           // RULE7
   end
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         status <= '0;
      end else begin
         status <= (status & ~((reg_wr_i && hit(reg_addr_i, spe_pkg::ADDR_STATUS))
                    ? reg_wdata_i[spe_pkg::STATUS_W-1:0] : '0)) | st_set; // RULE1
      end
   end
   assign irq_o = |(status & int_enable) & global_interrupt_enable; // RULE23 RULE2 RULE4 RULE6

   // =========================================================
   // taskfile shadow and slot bookkeeping
   logic rx_good_d2h;
   assign rx_good_d2h = rx_end & ~rx_bad & ~rx_stale & link_ev_i.rx_d2h_reg;
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         taskfile_busy         <= 1'b0;
         taskfile_data_request <= 1'b0;
      end else if (rx_good_d2h) begin
         taskfile_busy         <= ~link_ev_i.rx_clears_all; // RULE18
         taskfile_data_request <= ~link_ev_i.rx_clears_all;
      end else if (reg_wr_i && hit(reg_addr_i, spe_pkg::ADDR_ISSUED) && |reg_wdata_i) begin
         taskfile_busy         <= 1'b1;
      end
   end

   logic [SLOTS-1:0] slot_done;
   assign slot_done = (rx_good_d2h & link_ev_i.rx_clears_all)
                      ? (SLOTS'(1) << link_ev_i.rx_slot) : '0; // RULE20
   always_ff @(posedge sys_clk_i) begin
      if (srst_i | ~port_run_bit) begin
         issued_command_bits <= '0;
         queued_active_bits  <= '0;
      end else begin
         issued_command_bits <= (issued_command_bits & ~slot_done)
            | ((reg_wr_i && hit(reg_addr_i, spe_pkg::ADDR_ISSUED)) ? reg_wdata_i[SLOTS-1:0] : '0);
         queued_active_bits  <= queued_active_bits
            | ((reg_wr_i && hit(reg_addr_i, spe_pkg::ADDR_QUEUED)) ? reg_wdata_i[SLOTS-1:0] : '0);
      end
   end
   // completion tells the scheduler that multiplier port may take its next slot
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         done_valid_o <= 1'b0;
         done_slot_o  <= '0;
      end else begin
         done_valid_o <= |slot_done;          // RULE21
         done_slot_o  <= link_ev_i.rx_slot;
      end
   end

   // =========================================================
   // control and enable registers
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         int_enable              <= '0;
         port_run_bit            <= 1'b0;
         global_interrupt_enable <= 1'b0;
      end else if (reg_wr_i) begin
         if (hit(reg_addr_i, spe_pkg::ADDR_ENABLE)) begin
            int_enable <= reg_wdata_i[spe_pkg::STATUS_W-1:0];
         end
         if (hit(reg_addr_i, spe_pkg::ADDR_CONTROL)) begin
            port_run_bit            <= reg_wdata_i[spe_pkg::CT_RUN];
            global_interrupt_enable <= reg_wdata_i[spe_pkg::CT_GIE];
         end
      end
   end

   // =========================================================
   // read port, data in the cycle after the strobe
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         reg_rdata_o <= '0;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            spe_pkg::ADDR_STATUS:  reg_rdata_o <= 32'(status);
            spe_pkg::ADDR_ENABLE:  reg_rdata_o <= 32'(int_enable);
            spe_pkg::ADDR_LINKERR: reg_rdata_o <= 32'(link_error_register);
            spe_pkg::ADDR_CONTROL: reg_rdata_o <= 32'({global_interrupt_enable, port_run_bit});
            spe_pkg::ADDR_ISSUED:  reg_rdata_o <= 32'(issued_command_bits);
            spe_pkg::ADDR_QUEUED:  reg_rdata_o <= 32'(queued_active_bits);
            spe_pkg::ADDR_STATE:   reg_rdata_o <= 32'({taskfile_data_request, taskfile_busy,
                                                       poison, data_halt, fetch_stop, retry_pend, idle});
            default:               reg_rdata_o <= '0;
         endcase
      end else begin
         reg_rdata_o <= '0;
      end
   end

   // =========================================================
   // checks
   AST_ABORT_FLAG: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE2
      mem_ev_i.abort |=> status[spe_pkg::ST_HBF]) else $error("abort did not set fatal flag");
   AST_DATA_FLAG: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE4
      mem_ev_i.data_err |=> status[spe_pkg::ST_HBD]) else $error("data error flag missing");
   AST_FETCH_STOP: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE3
      (mem_ev_i.data_err & mem_ev_i.on_fetch & port_run_bit) |=> cmd_stopped_o) else $error("no stop");
   AST_IRQ: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE23
      irq_o |-> global_interrupt_enable && |(status & int_enable)) else $error("irq without cause");
   AST_CRC_RERR: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE13
      (rx_end & link_ev_i.rx_crc_bad & ~rx_stale) |=> rx_resp_o == spe_pkg::RSP_ERR
         && link_error_register[spe_pkg::LE_CRC] && idle) else $error("crc error not handled");
   AST_HSHK: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE16
      link_ev_i.tx_done_err |=> link_error_register[spe_pkg::LE_HSHK]) else $error("handshake bit");
   AST_STALE: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE17
      (rx_end & rx_stale) |=> rx_resp_o == spe_pkg::RSP_OK && !rx_post_o) else $error("stale frame");
   AST_PHY_QUIET: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE12
      (phy_drop & ~in_frame & ~rx_end & ~link_ev_i.tx_done_err) |=> !$rose(status[spe_pkg::ST_INF])
         && !$rose(status[spe_pkg::ST_IFF])) else $error("flag on quiet drop");
   AST_CI_CLEAR: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE20
      (|slot_done & port_run_bit & ~reg_wr_i) |=> ~|(issued_command_bits & $past(slot_done)))
      else $error("slot not cleared");
   AST_NONFATAL: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE7
      (link_ev_i.tx_done_err & ~link_ev_i.tx_is_data & port_run_bit) |=>
         status[spe_pkg::ST_INF] && retry_pend) else $error("non-data failure not retried");
   AST_DISP_BIT: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE11
      (rx_end & link_ev_i.rx_disp_d & in_frame & ~rx_stale) |=> rx_resp_o == spe_pkg::RSP_ERR
         && link_error_register[spe_pkg::LE_DISP]) else $error("disparity not reported");
   AST_PHY_IDLE: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE12
      phy_drop |=> idle) else $error("no idle after phy drop");
   // accepted activate, then a single launch pulse
   sequence act_taken;
      rx_end & link_ev_i.rx_dma_activate & ~rx_bad & tx_more_data_i & ~cmd_stopped_o;
   endsequence
   sequence one_frame;
      tx_data_frame_o ##1 !tx_data_frame_o;
   endsequence
   AST_DMA_FRAME: assert property (@(posedge sys_clk_i) disable iff (srst_i) // RULE22
      act_taken |=> one_frame) else $error("activate did not send one frame");

endmodule // spe_port_err

/* File: tb_top.sv */
// self-checking bench for the port error reporting block
`timescale 1ns/1ps
module tb_top;
   logic sys_clk_i = 1'b0, srst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, phy_link_up_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
   logic tx_more_data_i = 1'b0, nak = 1'b0, d, rx_post_o, decoder_disp_reset_o, tx_crc_poison_o, tx_retry_o;
   logic tx_data_frame_o, cmd_stopped_o, port_idle_o, done_valid_o, irq_o;
   logic [4:0] done_slot_o;
   spe_pkg::spe_link_ev_t link_ev_i, ev;
   spe_pkg::spe_mem_ev_t mem_ev_i = '0;
   spe_pkg::spe_resp_t rx_resp_o;
   int miscompares = 0, n_checks = 0, kres = 0, exp_st = 0, exp_le = 0, exp_ci = 0;
   int sl[3] = '{0, 5, 2};
   spe_port_err i_dut (.sys_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
      .phy_link_up_i, .link_ev_i, .mem_ev_i, .tx_more_data_i, .rx_resp_o, .rx_post_o, .decoder_disp_reset_o,
      .tx_crc_poison_o, .tx_retry_o, .tx_data_frame_o, .cmd_stopped_o, .port_idle_o, .done_slot_o,
      .done_valid_o, .irq_o);
   spe_far_dev i_far (.sys_clk_i, .tx_data_frame_i(tx_data_frame_o), .nak_data_i(nak), .link_ev_o(link_ev_i));
   initial forever #4 sys_clk_i = ~sys_clk_i;
   always @(negedge sys_clk_i) if (decoder_disp_reset_o === 1'b1) kres++;
   // =========================================================
   // bus and compare helpers
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
      #1;
   endtask
   task automatic cr(input logic [7:0] a, input logic [31:0] exp);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, exp);
   endtask
   task automatic snd(input spe_pkg::spe_link_ev_t e);
      i_far.send(e);
      #1;
   endtask
   task automatic mem(input logic ab, de, fe, pa);
      @(posedge sys_clk_i);
      mem_ev_i <= '{ab, de, fe, pa};
      @(posedge sys_clk_i);
      mem_ev_i <= '0;
      #1;
   endtask
   task automatic clr;
      wr(spe_pkg::ADDR_STATUS, 32'hF);
      wr(spe_pkg::ADDR_LINKERR, 32'hF);
      wr(spe_pkg::ADDR_CONTROL, 32'h2);
      wr(spe_pkg::ADDR_CONTROL, 32'h3);
      exp_st = 0;
      exp_le = 0;
   endtask
   // good activate; a data frame must follow within three cycles
   task automatic act(output logic seen);
      ev = fr(1'b1, 1'b1, 14'h0004, 1'b0);
      ev.rx_dma_activate = 1'b1;
      ev.rx_slot = 5'($urandom);
      snd(ev);
      for (int k = 0; k < 3 && tx_data_frame_o !== 1'b1; k++) @(negedge sys_clk_i);
      seen = tx_data_frame_o;
      repeat (3) @(posedge sys_clk_i);
   endtask
   function automatic spe_pkg::spe_link_ev_t fr(input logic kn, ok, input logic [13:0] len, input logic dat);
      fr = '0;
      fr.rx_frame_end = 1'b1;
      fr.rx_in_frame = 1'b1;
      fr.rx_known = kn;
      fr.rx_len_ok = ok;
      fr.rx_len = len;
      fr.rx_is_data = dat;
   endfunction
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      #100000;
      miscompares++;
      print_verdict();
   end
   // =========================================================
   // scenarios
   initial begin
      void'($urandom(55));
      repeat (8) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      chk(port_idle_o, 1'b1);
      cr(spe_pkg::ADDR_STATUS, 0);
      cr(8'h1C, 0);
      wr(spe_pkg::ADDR_ENABLE, 32'hF);
      wr(spe_pkg::ADDR_CONTROL, 32'h3);
      mem(1, 0, 0, 0);
      exp_st = 1 << spe_pkg::ST_HBF;
      cr(spe_pkg::ADDR_STATUS, exp_st);
      chk(irq_o, 1'b1);
      wr(spe_pkg::ADDR_ENABLE, 32'hE);
      chk(irq_o, 1'b0);
      wr(spe_pkg::ADDR_ENABLE, 32'hF);
      clr();
      chk(irq_o, 1'b0);
      mem(0, 1, 0, 1);
      exp_st = 1 << spe_pkg::ST_HBD;
      cr(spe_pkg::ADDR_STATUS, exp_st);
      chk(tx_crc_poison_o, 1'b1);
      chk(cmd_stopped_o, 1'b0);
      clr();
      chk(tx_crc_poison_o, 1'b0);
      mem(0, 1, 1, 0);
      chk(cmd_stopped_o, 1'b1);
      cr(spe_pkg::ADDR_STATUS, 1 << spe_pkg::ST_HBD);
      clr();
      for (int i = 0; i < 4; i++) begin
         d = 1'($urandom_range(0, 1));
         ev = fr(1'b1, i != 1, 14'h0014, d);
         ev.rx_crc_bad = (i == 0);
         ev.rx_overflow = (i == 2);
         ev.rx_disp_d = (i == 3);
         snd(ev);
         chk(rx_resp_o, spe_pkg::RSP_ERR);
         chk(rx_post_o, 1'b0);
         exp_le |= 1 << (i == 0 ? spe_pkg::LE_CRC : i == 3 ? spe_pkg::LE_DISP : spe_pkg::LE_PROTO);
         if (i != 3) exp_st |= 1 << (d ? spe_pkg::ST_IFF : spe_pkg::ST_INF);
         cr(spe_pkg::ADDR_LINKERR, exp_le);
         cr(spe_pkg::ADDR_STATUS, exp_st);
      end
      clr();
      for (int n = 64; n < 66; n++) begin
         snd(fr(1'b0, 1'b0, 14'(n), 1'b0));
         chk(rx_resp_o, n == 64 ? spe_pkg::RSP_OK : spe_pkg::RSP_ERR);
         chk(rx_post_o, n == 64);
      end
      cr(spe_pkg::ADDR_LINKERR, 1 << spe_pkg::LE_PROTO);
      clr();
      ev = '0;
      ev.rx_disp_k = 1'b1;
      ev.rx_in_frame = 1'b1;
      snd(ev);
      chk(kres, 1);
      cr(spe_pkg::ADDR_LINKERR, 0);
      ev = fr(1'b1, 1'b1, 14'h0014, 1'b0);
      ev.rx_upd_bsy_drq = 1'b1;
      snd(ev);
      chk(rx_resp_o, spe_pkg::RSP_OK);
      chk(rx_post_o, 1'b0);
      cr(spe_pkg::ADDR_STATUS, 0);
      wr(spe_pkg::ADDR_ISSUED, 32'h25);
      exp_ci = 32'h25;
      tx_more_data_i <= 1'b1;
      foreach (sl[i]) begin
         ev = fr(1'b1, 1'b1, 14'h0014, 1'b0);
         ev.rx_d2h_reg = 1'b1;
         ev.rx_clears_all = 1'b1;
         ev.rx_slot = 5'(sl[i]);
         snd(ev);
         for (int k = 0; k < 3 && done_valid_o !== 1'b1; k++) @(negedge sys_clk_i);
         chk(done_slot_o, sl[i]);
         exp_ci &= ~(1 << sl[i]);
         cr(spe_pkg::ADDR_ISSUED, exp_ci);
         act(d);
         chk(d, 1'b1);
      end
      chk(i_far.acks, 3);
      tx_more_data_i <= 1'b0;
      act(d);
      chk(d, 1'b0);
      nak <= 1'b1;
      tx_more_data_i <= 1'b1;
      act(d);
      nak <= 1'b0;
      tx_more_data_i <= 1'b0;
      chk(tx_retry_o, 1'b0);
      cr(spe_pkg::ADDR_STATUS, 1 << spe_pkg::ST_IFF);
      cr(spe_pkg::ADDR_LINKERR, 1 << spe_pkg::LE_HSHK);
      clr();
      ev = '0;
      ev.tx_done_err = 1'b1;
      snd(ev);
      @(negedge sys_clk_i);
      chk(tx_retry_o, 1'b1);
      snd(fr(1'b0, 1'b0, 14'h0008, 1'b0));
      chk(rx_post_o, 1'b1);
      chk(tx_retry_o, 1'b1);
      cr(spe_pkg::ADDR_STATUS, 1 << spe_pkg::ST_INF);
      ev = '0;
      ev.tx_done_ok = 1'b1;
      snd(ev);
      @(negedge sys_clk_i);
      chk(tx_retry_o, 1'b0);
      ev = '0;
      ev.tx_done_err = 1'b1;
      snd(ev);
      wr(spe_pkg::ADDR_CONTROL, 32'h2);
      // retry flop clears one edge after the run bit falls
      repeat (2) @(negedge sys_clk_i);
      chk(tx_retry_o, 1'b0);
      clr();
      phy_link_up_i <= 1'b0;
      repeat (6) @(posedge sys_clk_i);
      cr(spe_pkg::ADDR_STATUS, 0);
      chk(port_idle_o, 1'b1);
      phy_link_up_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      // drop lands inside a non-data frame: non-fatal flag
      phy_link_up_i <= 1'b0;
      ev = '0;
      ev.rx_in_frame = 1'b1;
      @(posedge sys_clk_i);
      snd(ev);
      cr(spe_pkg::ADDR_STATUS, 1 << spe_pkg::ST_INF);
      chk(port_idle_o, 1'b1);
      print_verdict();
   end
endmodule // tb_top
